// file: fbm_flash_ctrl.sv
// flash block map, mode latch, protection and boot serial link front end
`timescale 1ns/10ps
`include "fbm_params.svh"
module fbm_flash_ctrl
  import fbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flash_write_permit_pin,
  input wire logic mode_select_2,
  input wire logic mode_select_1,
  input wire logic mode_select_0,
  input wire logic boot_serial_rx,
  output logic boot_serial_tx,
  input wire logic [15:0] accessAddr,
  output fbm_decode_t decode,
  input wire fbm_ctrl_t ctrlWrite,
  input wire logic ctrlWriteStrobe,
  input wire logic [7:0] eraseSelWrite,
  input wire logic eraseSelStrobe,
  input wire logic totalEraseReq,
  input wire logic bootTxValid,
  input wire logic [7:0] bootTxData,
  output logic bootTxReady,
  output logic [7:0] bootRxData,
  output logic bootRxValid,
  output fbm_ctrl_t ctrlState,
  output logic [7:0] erase_block_select,
  output fbm_mode_t modeState,
  output logic writePermitLevel,
  output fbm_op_t opActive,
  output logic [15:0] bootBitPeriod,
  output logic bootRateLocked,
  output logic bootLoadActive,
  output logic [7:0] eraseFillByte
);
  // pin synchronisers: first stage feeds the second stage only
  logic [2:0] modeMeta_r, modeSync_r;
  logic permitMeta_r, permitSync_r;
  logic rxMeta_r, rxSync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeMeta_r <= 3'h0;
      modeSync_r <= 3'h0;
      permitMeta_r <= 1'b0;
      permitSync_r <= 1'b0;
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      modeMeta_r <= {mode_select_2, mode_select_1, mode_select_0};
      modeSync_r <= modeMeta_r;
      permitMeta_r <= flash_write_permit_pin;
      permitSync_r <= permitMeta_r;
      rxMeta_r <= boot_serial_rx;
      rxSync_r <= rxMeta_r;
    end
  end

  // mode latch: caught once, after the synchronisers have settled past reset release
  logic [1:0] settle_r, settle_nxt;
  fbm_mode_t mode_r, mode_nxt;

  always_comb begin
    settle_nxt = settle_r;
    mode_nxt = mode_r;
    if (settle_r != 2'h3) begin
      settle_nxt = 2'(settle_r + 2'h1);
    end
    if (settle_r == 2'h2) begin
      if (!permitSync_r) begin
        mode_nxt = FBM_MODE_USER;
      end else if (modeSync_r[2] && modeSync_r[1:0] == 2'h0) begin
        mode_nxt = FBM_MODE_PROGRAMMER;
      end else if (modeSync_r[1]) begin
        mode_nxt = FBM_MODE_USER_PROG;
      end else begin
        mode_nxt = FBM_MODE_BOOT;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= 2'h0;
      mode_r <= FBM_MODE_NONE;
    end else begin
      settle_r <= settle_nxt;
      mode_r <= mode_nxt;
    end
  end

  // address decode into erase block and programming unit
  logic [2:0] blockIdx;
  always_comb begin
    if (accessAddr >= `FBM_BLK7_BASE) begin
      blockIdx = 3'h7;
    end else if (accessAddr >= `FBM_BLK6_BASE) begin
      blockIdx = 3'h6;
    end else if (accessAddr >= `FBM_BLK5_BASE) begin
      blockIdx = 3'h5;
    end else if (accessAddr >= `FBM_BLK4_BASE) begin
      blockIdx = 3'h4;
    end else begin
      blockIdx = 3'(accessAddr >> `FBM_KB_SHIFT);
    end
  end

  fbm_decode_t decode_r, decode_nxt;
  always_comb begin
    decode_nxt.block = blockIdx;
    // unit base low byte 00 or 80
    decode_nxt.unitBase = accessAddr & ~{8'h00, `FBM_UNIT_MASK};
    decode_nxt.unitStart = (accessAddr[7:0] == `FBM_UNIT_LO0) || (accessAddr[7:0] == `FBM_UNIT_LO1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      decode_r <= '0;
    end else begin
      decode_r <= decode_nxt;
    end
  end

  // permission: pin lock, mode, software permit
  logic pinAllows, writeMode, blockMode, bootMode;
  always_comb begin
    pinAllows = permitSync_r;
    writeMode = pinAllows && (mode_r == FBM_MODE_USER_PROG || mode_r == FBM_MODE_BOOT
                || mode_r == FBM_MODE_PROGRAMMER);
    // per-block erase in user program and programmer modes
    blockMode = pinAllows && (mode_r == FBM_MODE_USER_PROG || mode_r == FBM_MODE_PROGRAMMER);
    bootMode = pinAllows && (mode_r == FBM_MODE_BOOT);
  end

  // control bits and erase block select
  fbm_ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] ebSel_r, ebSel_nxt;
  fbm_op_t op_r, op_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    ebSel_nxt = ebSel_r;
    op_nxt = op_r;
    if (ctrlWriteStrobe) begin
      // software permit gates the other bits
      ctrl_nxt.softWritePermit = ctrlWrite.softWritePermit && writeMode;
      ctrl_nxt.programSetup = ctrlWrite.programSetup && ctrl_nxt.softWritePermit;
      ctrl_nxt.eraseSetup = ctrlWrite.eraseSetup && ctrl_nxt.softWritePermit;
      // program needs permit and setup already set
      ctrl_nxt.programBit = ctrlWrite.programBit && ctrl_r.softWritePermit && ctrl_r.programSetup
                            && ctrl_nxt.programSetup;
      ctrl_nxt.eraseBit = ctrlWrite.eraseBit && ctrl_r.softWritePermit && ctrl_r.eraseSetup
                          && ctrl_nxt.eraseSetup && blockMode;
    end
    if (eraseSelStrobe && ctrl_r.softWritePermit && blockMode) begin
      // more than one select clears all
      ebSel_nxt = ($countones(eraseSelWrite) > 1) ? 8'h00 : eraseSelWrite;
    end
    if (!writeMode || !ctrl_nxt.softWritePermit) begin
      ctrl_nxt = '0;
      ebSel_nxt = 8'h00;
    end
    // one block erase at a time
    if (ctrl_nxt.eraseBit && ebSel_nxt != 8'h00) begin
      op_nxt = FBM_OP_ERASE;
    end else if (ctrl_nxt.programBit) begin
      op_nxt = FBM_OP_PROG;
    end else if (op_r == FBM_OP_TOTAL && bootMode && ctrl_nxt.softWritePermit) begin
      op_nxt = FBM_OP_TOTAL;
    // total erase only in boot mode
    end else if (totalEraseReq && bootMode && ctrl_r.softWritePermit) begin
      op_nxt = FBM_OP_TOTAL;
    end else begin
      op_nxt = FBM_OP_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= '0;
      ebSel_r <= 8'h00;
      op_r <= FBM_OP_IDLE;
    end else begin
      ctrl_r <= ctrl_nxt;
      ebSel_r <= ebSel_nxt;
      op_r <= op_nxt;
    end
  end

  logic [15:0] bitPeriod;
  logic rateLocked;
  fbm_baud_meter u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .enable(mode_r == FBM_MODE_BOOT),
    .rxSync(rxSync_r),
    .bitPeriod(bitPeriod),
    .locked(rateLocked)
  );

  // boot serial receiver and transmitter, 8N1 at the measured rate
  logic [15:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt;
  logic [3:0] rxBit_r, rxBit_nxt, txBit_r, txBit_nxt;
  logic [7:0] rxShift_r, rxShift_nxt;
  logic [8:0] txShift_r, txShift_nxt;
  logic rxBusy_r, rxBusy_nxt, rxValid_r, rxValid_nxt, txBusy_r, txBusy_nxt, txOut_r, txOut_nxt;
  logic rateSeen_r, rateSeen_nxt;

  always_comb begin
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxShift_nxt = rxShift_r;
    rxBusy_nxt = rxBusy_r;
    rxValid_nxt = 1'b0;
    rateSeen_nxt = rateSeen_r || rateLocked;
    // bytes only after rate match, fed to the boot loader
    if (!rxBusy_r) begin
      // skip the measuring byte itself: wait for line idle after lock
      if (rateLocked && rateSeen_r && rxSync_r == 1'b0) begin
        rxBusy_nxt = 1'b1;
        rxCnt_nxt = bitPeriod >> 1;
        rxBit_nxt = 4'h0;
      end
    end else if (rxCnt_r != 16'h0000) begin
      rxCnt_nxt = 16'(rxCnt_r - 16'h0001);
    end else begin
      rxCnt_nxt = bitPeriod;
      rxBit_nxt = 4'(rxBit_r + 4'h1);
      if (rxBit_r >= 4'h1 && rxBit_r <= `FBM_BAUD_SAMPLES) begin
        rxShift_nxt = {rxSync_r, rxShift_r[7:1]};
      end
      if (rxBit_r == 4'h9) begin
        rxBusy_nxt = 1'b0;
        rxValid_nxt = rxSync_r;
      end
    end
    if (mode_r != FBM_MODE_BOOT) begin
      rxBusy_nxt = 1'b0;
      rateSeen_nxt = 1'b0;
    end
  end

  always_comb begin
    txCnt_nxt = txCnt_r;
    txBit_nxt = txBit_r;
    txShift_nxt = txShift_r;
    txBusy_nxt = txBusy_r;
    txOut_nxt = txOut_r;
    if (!txBusy_r) begin
      txOut_nxt = 1'b1;
      if (bootTxValid && rateLocked) begin
        txBusy_nxt = 1'b1;
        txShift_nxt = {1'b1, bootTxData};
        txOut_nxt = 1'b0;
        txCnt_nxt = bitPeriod;
        txBit_nxt = 4'h0;
      end
    end else if (txCnt_r != 16'h0000) begin
      txCnt_nxt = 16'(txCnt_r - 16'h0001);
    end else begin
      txCnt_nxt = bitPeriod;
      txBit_nxt = 4'(txBit_r + 4'h1);
      txOut_nxt = txShift_r[0];
      txShift_nxt = {1'b1, txShift_r[8:1]};
      if (txBit_r == 4'h9) begin
        txBusy_nxt = 1'b0;
        txOut_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt_r <= 16'h0000;
      rxBit_r <= 4'h0;
      rxShift_r <= 8'h00;
      rxBusy_r <= 1'b0;
      rxValid_r <= 1'b0;
      rateSeen_r <= 1'b0;
      txCnt_r <= 16'h0000;
      txBit_r <= 4'h0;
      txShift_r <= 9'h1FF;
      txBusy_r <= 1'b0;
      txOut_r <= 1'b1;
    end else begin
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxShift_r <= rxShift_nxt;
      rxBusy_r <= rxBusy_nxt;
      rxValid_r <= rxValid_nxt;
      rateSeen_r <= rateSeen_nxt;
      txCnt_r <= txCnt_nxt;
      txBit_r <= txBit_nxt;
      txShift_r <= txShift_nxt;
      txBusy_r <= txBusy_nxt;
      txOut_r <= txOut_nxt;
    end
  end

  // outputs; bootTxReady is combinational handshake
  assign boot_serial_tx = txOut_r;
  assign bootTxReady = !txBusy_r && rateLocked;
  assign bootRxData = rxShift_r;
  assign bootRxValid = rxValid_r;
  assign decode = decode_r;
  assign ctrlState = ctrl_r;
  assign erase_block_select = ebSel_r;
  assign modeState = mode_r;
  assign writePermitLevel = permitSync_r;
  assign opActive = op_r;
  assign bootBitPeriod = bitPeriod;
  assign bootRateLocked = rateLocked;
  assign bootLoadActive = (mode_r == FBM_MODE_BOOT);
  assign eraseFillByte = `FBM_ERASED_BYTE;
endmodule // fbm_flash_ctrl

// file: fbm_params.svh
// constants for the flash block map and mode control block
`ifndef FBM_PARAMS_SVH
`define FBM_PARAMS_SVH
`define FBM_ADDR_W 16
`define FBM_BLK4_BASE 16'h1000
`define FBM_BLK5_BASE 16'h8000
`define FBM_BLK6_BASE 16'hC000
`define FBM_BLK7_BASE 16'hE000
`define FBM_KB_SHIFT 10
`define FBM_UNIT_MASK 8'h7F
`define FBM_UNIT_LO0 8'h00
`define FBM_UNIT_LO1 8'h80
`define FBM_UNIT_BYTES 8'h80
`define FBM_ERASED_BYTE 8'hFF
`define FBM_BAUD_MAX 16'hFFFF
`define FBM_BAUD_RESET 16'h0364
`define FBM_BAUD_SAMPLES 4'h8
`endif

// file: fbm_pkg.sv
// types shared by the flash block map and mode control files
package fbm_pkg;
  typedef enum logic [2:0] {
    FBM_MODE_USER = 3'h0,
    FBM_MODE_USER_PROG = 3'h1,
    FBM_MODE_BOOT = 3'h3,
    FBM_MODE_PROGRAMMER = 3'h2,
    FBM_MODE_NONE = 3'h6
  } fbm_mode_t;

  typedef enum logic [1:0] {
    FBM_OP_IDLE = 2'h0,
    FBM_OP_PROG = 2'h1,
    FBM_OP_ERASE = 2'h3,
    FBM_OP_TOTAL = 2'h2
  } fbm_op_t;

  typedef struct packed {
    logic softWritePermit;
    logic eraseSetup;
    logic programSetup;
    logic eraseBit;
    logic programBit;
  } fbm_ctrl_t;

  typedef struct packed {
    logic [15:0] unitBase;
    logic [2:0] block;
    logic unitStart;
  } fbm_decode_t;
endpackage

// file: fbm_baud_meter.sv
// boot serial bit rate meter: times the host's nine-bit low run and derives the bit period
`timescale 1ns/10ps
`include "fbm_params.svh"
module fbm_baud_meter
  import fbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rxSync,
  output logic [15:0] bitPeriod,
  output logic locked
);
  typedef enum logic [1:0] {
    FBM_BM_WAIT = 2'h0,
    FBM_BM_LOW = 2'h1,
    FBM_BM_DONE = 2'h3
  } fbm_bm_state_t;

  fbm_bm_state_t state_r, state_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] period_r, period_nxt;

  // the host sends a 00h byte: start bit plus eight zero bits form one low run of nine bit times
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    period_nxt = period_r;
    case (state_r)
      FBM_BM_WAIT: begin
        count_nxt = 16'h0000;
        if (enable && !rxSync) begin
          state_nxt = FBM_BM_LOW;
        end
      end
      FBM_BM_LOW: begin
        if (rxSync) begin
          // low run is nine bits long; divide by nine, rounding down
          period_nxt = 16'((32'(count_r) * 32'h0000_1C72) >> 16);
          state_nxt = FBM_BM_DONE;
        end else if (count_r != `FBM_BAUD_MAX) begin
          count_nxt = 16'(count_r + 16'h0001);
        end
      end
      FBM_BM_DONE: begin
        if (!enable) begin
          state_nxt = FBM_BM_WAIT;
        end
      end
      default: begin
        state_nxt = FBM_BM_WAIT;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= FBM_BM_WAIT;
      count_r <= 16'h0000;
      period_r <= `FBM_BAUD_RESET;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      period_r <= period_nxt;
    end
  end

  assign bitPeriod = period_r;
  assign locked = (state_r == FBM_BM_DONE);
endmodule // fbm_baud_meter

// file: fbm_flash_ctrl_monitor.sv
// assertion checker bound to the flash block map top
`timescale 1ns/10ps
module fbm_flash_ctrl_monitor
  import fbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] accessAddr,
  input wire fbm_decode_t decode,
  input wire logic [7:0] eraseSelWrite,
  input wire logic eraseSelStrobe,
  input wire fbm_ctrl_t ctrlState,
  input wire logic [7:0] erase_block_select,
  input wire fbm_mode_t modeState,
  input wire logic writePermitLevel,
  input wire fbm_op_t opActive
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // decode lags the address by one cycle; skip the edge straight after reset
  property p_unit; $past(rst_n) |-> decode.unitStart == ($past(accessAddr[6:0]) == 7'h00); endproperty
  a_unit: assert property (p_unit) else $error("unit start flag wrong");
  property p_base; $past(rst_n) |-> decode.unitBase == ($past(accessAddr) & 16'hFF80); endproperty
  a_base: assert property (p_base) else $error("unit base wrong");
  property p_low; $past(rst_n) && $past(accessAddr) < 16'h1000 |-> decode.block == $past(accessAddr[12:10]); endproperty
  a_low: assert property (p_low) else $error("small block number wrong");
  property p_top; $past(rst_n) && $past(accessAddr) >= 16'hC000 |-> decode.block == {2'b11, $past(accessAddr[13])}; endproperty
  a_top: assert property (p_top) else $error("upper block number wrong");
  // operation gating by mode and pins
  property p_user; modeState == FBM_MODE_USER |-> opActive == FBM_OP_IDLE; endproperty
  a_user: assert property (p_user) else $error("operation in read-only mode");
  property p_pin; !writePermitLevel |=> ctrlState == 5'h00 && erase_block_select == 8'h00; endproperty
  a_pin: assert property (p_pin) else $error("control kept without pin");
  property p_multi; eraseSelStrobe && $countones(eraseSelWrite) > 1 |=> erase_block_select == 8'h00; endproperty
  a_multi: assert property (p_multi) else $error("multiple selects kept");
  property p_boot; modeState == FBM_MODE_BOOT |-> erase_block_select == 8'h00 && opActive != FBM_OP_ERASE; endproperty
  a_boot: assert property (p_boot) else $error("block erase in boot mode");
  property p_prog; $rose(ctrlState.programBit) |-> $past(ctrlState.programSetup) && $past(ctrlState.softWritePermit);
  endproperty
  a_prog: assert property (p_prog) else $error("program bit without setup");
  property p_mode; $past(modeState) != FBM_MODE_NONE |-> $stable(modeState); endproperty
  a_mode: assert property (p_mode) else $error("mode changed after latch");
endmodule // fbm_flash_ctrl_monitor

bind fbm_flash_ctrl fbm_flash_ctrl_monitor u_mon (.clk, .rst_n, .accessAddr, .decode, .eraseSelWrite,
  .eraseSelStrobe, .ctrlState, .erase_block_select, .modeState, .writePermitLevel, .opActive);

// file: fbm_boot_host.sv
// serial boot host model: rate byte then one data byte
`timescale 1ns/10ps
module fbm_boot_host #(parameter int BIT_CYC = 32) (
  input wire logic clk,
  input wire logic go,
  output logic serialOut
);
  // frames on rx pin, 8N1 lsb first
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serialOut <= frame[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask

  // zero byte gives a nine-bit low run to time
  initial begin
    serialOut = 1'b1;
    wait (go);
    @(posedge clk);
    sendByte(8'h00);
    repeat (4 * BIT_CYC) @(posedge clk);
    sendByte(8'hA5);
  end
endmodule // fbm_boot_host

// file: fbm_flash_ctrl_tb.sv
// self-checking bench for the flash block map and mode control
`timescale 1ns/10ps
module fbm_flash_ctrl_tb
  import fbm_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, permit = 1'b0, selStb = 1'b0, ctrlStb = 1'b0, totalReq = 1'b0;
  logic txValid = 1'b0, hostGo = 1'b0;
  logic [2:0] md = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] selW = 8'h00, txData = 8'h00;
  fbm_ctrl_t ctrlW = 5'h00;
  logic rxLine, txLine, txReady, rxValid, rateLocked, loadActive, permitLvl;
  fbm_decode_t dec;
  fbm_ctrl_t ctrlSt;
  fbm_mode_t mode;
  fbm_op_t op;
  logic [7:0] rxData, selSt, fill, txByte;
  logic [15:0] bitPer;
  int nFail = 0, samplesChecked = 0, cycles = 0;
  logic [15:0] addrs [10] = '{16'h0000, 16'h0480, 16'h0BFF, 16'h0F80, 16'h1000, 16'h7FFF, 16'h8000,
    16'hC07F, 16'hE000, 16'hFFFF};

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  fbm_flash_ctrl uut (.clk(clk), .rst_n(rst_n), .flash_write_permit_pin(permit), .mode_select_2(md[2]),
    .mode_select_1(md[1]), .mode_select_0(md[0]), .boot_serial_rx(rxLine), .boot_serial_tx(txLine),
    .accessAddr(addr), .decode(dec), .ctrlWrite(ctrlW), .ctrlWriteStrobe(ctrlStb), .eraseSelWrite(selW),
    .eraseSelStrobe(selStb), .totalEraseReq(totalReq), .bootTxValid(txValid), .bootTxData(txData),
    .bootTxReady(txReady), .bootRxData(rxData), .bootRxValid(rxValid), .ctrlState(ctrlSt),
    .erase_block_select(selSt), .modeState(mode), .writePermitLevel(permitLvl), .opActive(op),
    .bootBitPeriod(bitPer), .bootRateLocked(rateLocked), .bootLoadActive(loadActive), .eraseFillByte(fill));

  fbm_boot_host #(.BIT_CYC(32)) host (.clk(clk), .go(hostGo), .serialOut(rxLine));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // reset with pins set, mode read after the latch settles
  task automatic startMode(input logic pin, input logic [2:0] pins, input fbm_mode_t exp);
    @(posedge clk);
    rst_n <= 1'b0;
    permit <= pin;
    md <= pins;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(16'(mode), 16'(exp));
  endtask

  // one-cycle strobe write of control bits or erase selects
  task automatic put(input logic sel, input logic [7:0] v);
    @(posedge clk);
    if (sel) begin
      selW <= v;
      selStb <= 1'b1;
    end else begin
      ctrlW <= fbm_ctrl_t'(v[4:0]);
      ctrlStb <= 1'b1;
    end
    @(posedge clk);
    selStb <= 1'b0;
    ctrlStb <= 1'b0;
    #1;
  endtask

  function automatic logic [2:0] expBlk(input logic [15:0] a);
    return a < 16'h1000 ? a[12:10] : a < 16'h8000 ? 3'h4 : a < 16'hC000 ? 3'h5 : a < 16'hE000 ? 3'h6 : 3'h7;
  endfunction

  // cycle ceiling so a hung wait still reaches the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      test_done;
    end
  end

  // main sequence: read-only, user program, programmer, boot
  initial begin
    startMode(1'b0, 3'h0, FBM_MODE_USER);
    put(1'b0, 8'h10);
    chk(16'(ctrlSt), 16'h0000);
    foreach (addrs[i]) begin
      @(posedge clk);
      addr <= addrs[i];
      @(posedge clk);
      #1;
      chk(16'(dec.block), 16'(expBlk(addrs[i])));
      chk(dec.unitBase, addrs[i] & 16'hFF80);
      chk(16'(dec.unitStart), 16'(addrs[i][6:0] == 7'h00));
    end
    startMode(1'b1, 3'h2, FBM_MODE_USER_PROG);
    put(1'b0, 8'h11);
    chk(16'(ctrlSt), 16'h0010);
    put(1'b0, 8'h14);
    put(1'b0, 8'h15);
    chk(16'(op), 16'(FBM_OP_PROG));
    put(1'b0, 8'h14);
    chk(16'(op), 16'(FBM_OP_IDLE));
    put(1'b1, 8'h30);
    chk(16'(selSt), 16'h0000);
    put(1'b1, 8'h20);
    chk(16'(selSt), 16'h0020);
    put(1'b0, 8'h18);
    put(1'b0, 8'h1A);
    chk(16'(op), 16'(FBM_OP_ERASE));
    // drop the erase bit first so a wrongly granted total erase would show
    put(1'b0, 8'h10);
    @(posedge clk);
    totalReq <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(op), 16'(FBM_OP_IDLE));
    @(posedge clk);
    totalReq <= 1'b0;
    put(1'b0, 8'h00);
    put(1'b1, 8'h01);
    chk(16'(selSt), 16'h0000);
    @(posedge clk);
    permit <= 1'b0;
    repeat (4) @(posedge clk);
    put(1'b0, 8'h10);
    chk(16'(permitLvl), 16'h0000);
    chk(16'(ctrlSt), 16'h0000);
    chk(16'(op), 16'(FBM_OP_IDLE));
    startMode(1'b1, 3'h4, FBM_MODE_PROGRAMMER);
    put(1'b0, 8'h10);
    put(1'b1, 8'h80);
    chk(16'(selSt), 16'h0080);
    startMode(1'b1, 3'h1, FBM_MODE_BOOT);
    chk(16'(loadActive), 16'h0001);
    put(1'b0, 8'h10);
    put(1'b1, 8'h04);
    chk(16'(selSt), 16'h0000);
    @(posedge clk);
    totalReq <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(op), 16'(FBM_OP_TOTAL));
    chk(16'(fill), 16'h00FF);
    @(posedge clk);
    totalReq <= 1'b0;
    hostGo <= 1'b1;
    for (int i = 0; i < 3000 && rxValid !== 1'b1; i++) @(negedge clk);
    chk(16'(rxData), 16'h00A5);
    chk(16'(rateLocked), 16'h0001);
    // host bit is 32 cycles; the link runs bitPeriod plus one cycles per bit
    chk(16'(bitPer + 16'h0001), 16'h0020);
    @(posedge clk);
    txData <= 8'h3C;
    txValid <= 1'b1;
    for (int i = 0; i < 100 && txReady !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    txValid <= 1'b0;
    for (int i = 0; i < 100 && txLine !== 1'b0; i++) @(negedge clk);
    chk(16'(txLine), 16'h0000);
    // sample the sent frame mid bit, lsb first
    repeat (16) @(negedge clk);
    chk(16'(txLine), 16'h0000);
    for (int k = 0; k < 8; k++) begin
      repeat (32) @(negedge clk);
      txByte[k] = txLine;
    end
    repeat (32) @(negedge clk);
    chk(16'(txLine), 16'h0001);
    chk(16'(txByte), 16'h003C);
    test_done;
  end
endmodule // fbm_flash_ctrl_tb
